// ---- sar_adc_sequencer.sv ----
// sar adc sequencer: control registers, conversion timing, result and flags
`timescale 1ns/1ns
// Function
// (RULE_01) standby entry resets control register one and blocks its writes
// (RULE_02) standby entry resets control register two and blocks its writes
// (RULE_03) software writes bit0 as 0 and bit4 as 1 in control two
// (RULE_04) reading control two gives undefined bits 6 and 7
// (RULE_05) conversion time code selects 39..1248 clock periods; 001, 111 reserved
// (RULE_06) software avoids conversion times prohibited at its clock frequency
// (RULE_07) software mode: start bit begins one conversion of selected channel
// (RULE_08) completion stores result, sets end flag and raises done interrupt together
// (RULE_09) start bit clears itself once conversion begins
// (RULE_10) software never restarts during a conversion; waits for flag or interrupt
// (RULE_11) repeat mode: each completion immediately starts the next conversion
// (RULE_12) mode 00 halts conversion at once without storing partial result
// (RULE_13) reading the result clears the end flag
// (RULE_14) new start clears end flag but old result stays until completion
// (RULE_15) standby during conversion aborts, resets controls, discards results
// (RULE_16) after standby nothing resumes until software starts again
// (RULE_17) standby disconnects the reference ladder
// (RULE_18) result is 10 bits: upper 8 and lower 2 in two registers
// (RULE_19) software sets channel, input, mode, time and ladder before start
// (RULE_20) mode field: 00 disabled, 01 software, 10 reserved, 11 repeat
// (RULE_21) software changes channel only while busy flag reads 0
// (RULE_22) software sets analog input disable when no channel is used
// (RULE_23) busy flag is 1 from start until result stored or aborted
// (RULE_24) done interrupt is a one-cycle pulse together with end flag set
module sar_adc_sequencer (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [sar_adc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [sar_adc_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_standby,
    input wire logic [sar_adc_pkg::CODE_W-1:0] i_conv_code,
    output logic [sar_adc_pkg::DATA_W-1:0] o_rdata,
    output logic o_conversion_done_irq,
    output logic o_converter_busy_flag,
    output logic o_ladder_reference_on,
    output logic o_analog_input_disable,
    output logic [3:0] o_input_channel_select
);

    sar_adc_pkg::conv_control_one_t ctrl_one_r;
    sar_adc_pkg::conv_control_two_t ctrl_two_r;
    sar_adc_pkg::conv_state_t state_r;
    logic [sar_adc_pkg::CNT_W-1:0] cnt_r;
    logic [sar_adc_pkg::CODE_W-1:0] result_r;
    logic end_of_conversion_flag_r;
    logic irq_r;
    logic ladder_r;
    logic [sar_adc_pkg::DATA_W-1:0] rdata_r;

    logic wr_one;
    logic wr_two;
    logic rd_upper;
    logic mode_off;
    logic mode_active;
    logic conv_begin;
    logic conv_done;
    logic conv_abort;

    assign wr_one = i_wr && !i_standby && (i_addr == sar_adc_pkg::OFS_CONV_CONTROL_ONE);
    assign wr_two = i_wr && !i_standby && (i_addr == sar_adc_pkg::OFS_CONV_CONTROL_TWO);
    assign rd_upper = i_rd && (i_addr == sar_adc_pkg::OFS_CONV_RESULT_UPPER);
    assign mode_off = (ctrl_one_r.conversion_mode_select == sar_adc_pkg::MODE_DISABLED);
    assign mode_active = (ctrl_one_r.conversion_mode_select == sar_adc_pkg::MODE_SOFTWARE)
        || (ctrl_one_r.conversion_mode_select == sar_adc_pkg::MODE_REPEAT); // RULE_20
    // begin only from idle on a standing start bit
    assign conv_begin = (state_r == sar_adc_pkg::ST_IDLE) && ctrl_one_r.conversion_start_bit
        && mode_active && !i_standby; // RULE_07 RULE_11 RULE_16
    // halt through mode 00 or the reserved code, or standby
    assign conv_abort = (state_r == sar_adc_pkg::ST_CONV) && (i_standby || !mode_active); // RULE_12
    assign conv_done = (state_r == sar_adc_pkg::ST_CONV) && !conv_abort && (cnt_r == '0);

    // control register one
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_one_r <= sar_adc_pkg::CONV_CONTROL_ONE_RST;
        end
        else if (i_standby)
        begin
            ctrl_one_r <= sar_adc_pkg::CONV_CONTROL_ONE_RST; // RULE_01 RULE_15
        end
        else if (wr_one)
        begin
            ctrl_one_r <= i_wdata;
        end
        else if (conv_begin)
        begin
            ctrl_one_r.conversion_start_bit <= 1'b0; // RULE_09
        end
    end

    // control register two; bit0/bit4 stored as written, software keeps them fixed
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_two_r <= sar_adc_pkg::CONV_CONTROL_TWO_RST;
        end
        else if (i_standby)
        begin
            ctrl_two_r <= sar_adc_pkg::CONV_CONTROL_TWO_RST; // RULE_02 RULE_15
        end
        else if (wr_two)
        begin
            ctrl_two_r <= i_wdata; // RULE_03
        end
    end

    // conversion sequencer and length counter
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= sar_adc_pkg::ST_IDLE;
            cnt_r <= '0;
        end
        else
        begin
            unique case (state_r)
                sar_adc_pkg::ST_IDLE:
                begin
                    if (conv_begin)
                    begin
                        state_r <= sar_adc_pkg::ST_CONV; // RULE_23
                        cnt_r <= sar_adc_pkg::conv_ticks(ctrl_two_r.conv_time)
                            - 11'h001; // RULE_05
                    end
                end
                sar_adc_pkg::ST_CONV:
                begin
                    if (conv_abort)
                    begin
                        state_r <= sar_adc_pkg::ST_IDLE; // RULE_12 RULE_15
                    end
                    else if (conv_done)
                    begin
                        if (ctrl_one_r.conversion_mode_select == sar_adc_pkg::MODE_REPEAT)
                        begin
                            cnt_r <= sar_adc_pkg::conv_ticks(ctrl_two_r.conv_time)
                                - 11'h001; // RULE_11
                        end
                        else
                        begin
                            state_r <= sar_adc_pkg::ST_IDLE; // RULE_23
                        end
                    end
                    else
                    begin
                        cnt_r <= cnt_r - 11'h001;
                    end
                end
            endcase
        end
    end

    // result store: only on completion; standby discards it
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            result_r <= '0;
        end
        else if (i_standby)
        begin
            result_r <= '0; // RULE_15
        end
        else if (conv_done)
        begin
            result_r <= i_conv_code; // RULE_08 RULE_18
        end
    end

    // end flag: completion set wins over read clear
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            end_of_conversion_flag_r <= 1'b0;
        end
        else if (i_standby)
        begin
            end_of_conversion_flag_r <= 1'b0; // RULE_15
        end
        else if (conv_done)
        begin
            end_of_conversion_flag_r <= 1'b1; // RULE_08
        end
        else if (rd_upper || conv_begin)
        begin
            end_of_conversion_flag_r <= 1'b0; // RULE_13 RULE_14
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= conv_done; // RULE_08 RULE_24
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ladder_r <= 1'b0;
        end
        else
        begin
            ladder_r <= ctrl_two_r.ladder_reference_on && !i_standby; // RULE_17
        end
    end

    // read data, valid in the cycle after the read strobe
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rdata_r <= '0;
        end
        else if (i_rd)
        begin
            unique case (i_addr)
                sar_adc_pkg::OFS_CONV_CONTROL_ONE: rdata_r <= ctrl_one_r;
                sar_adc_pkg::OFS_CONV_CONTROL_TWO: rdata_r <= {2'h0, ctrl_two_r[5:0]}; // RULE_04
                sar_adc_pkg::OFS_CONV_RESULT_UPPER: rdata_r <= result_r[9:2]; // RULE_18
                sar_adc_pkg::OFS_CONV_RESULT_LOWER_STATUS:
                    rdata_r <= {result_r[1:0], end_of_conversion_flag_r, (state_r == sar_adc_pkg::ST_CONV),
                        4'h0}; // RULE_18 RULE_23
            endcase
        end
        else
        begin
            rdata_r <= '0;
        end
    end

    assign o_rdata = rdata_r;
    assign o_conversion_done_irq = irq_r;
    assign o_converter_busy_flag = (state_r == sar_adc_pkg::ST_CONV);
    assign o_ladder_reference_on = ladder_r;
    assign o_analog_input_disable = ctrl_one_r.analog_input_disable;
    assign o_input_channel_select = ctrl_one_r.input_channel_select;

    sequence s_fast_begin;
        conv_begin && (ctrl_two_r.conv_time == sar_adc_pkg::CT_39);
    endsequence

    sequence s_busy_then_done;
        (o_converter_busy_flag && !conv_done) [*8] ##31 conv_done;
    endsequence

    a_conv_length: assert property (@(posedge i_mclk) disable iff (!i_rst_n // RULE_05
        || i_standby || !mode_active) s_fast_begin |=> s_busy_then_done)
        else $error("shortest conversion did not finish after 39 cycles");

    a_done_flags: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_08
        conv_done && !i_standby |=> end_of_conversion_flag_r && o_conversion_done_irq
        && result_r == $past(i_conv_code))
        else $error("completion did not store result, flag and interrupt");

    a_irq_single: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_24
        o_conversion_done_irq |=> !o_conversion_done_irq)
        else $error("done interrupt longer than one cycle");

    a_start_clears: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_09 RULE_23
        conv_begin && !wr_one
        |=> !ctrl_one_r.conversion_start_bit && o_converter_busy_flag)
        else $error("start bit not cleared or busy not set on begin");

    a_begin_keeps: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_14
        conv_begin |=> !end_of_conversion_flag_r && $stable(result_r))
        else $error("restart lost old result or kept end flag");

    a_halt_discard: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_12
        conv_abort && !i_standby |=> !o_converter_busy_flag && $stable(result_r))
        else $error("halt stored partial result or kept running");

    a_repeat_next: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_11
        conv_done && ctrl_one_r.conversion_mode_select == sar_adc_pkg::MODE_REPEAT
        |=> o_converter_busy_flag)
        else $error("repeat mode did not continue");

    a_standby_init: assert property (@(posedge i_mclk) // RULE_01 RULE_02 RULE_15 RULE_17
        disable iff (!i_rst_n) i_standby |=> ctrl_one_r == sar_adc_pkg::CONV_CONTROL_ONE_RST
        && ctrl_two_r == sar_adc_pkg::CONV_CONTROL_TWO_RST && !o_converter_busy_flag
        && !o_ladder_reference_on && result_r == '0)
        else $error("standby did not initialise the converter");

    a_read_clears: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_13
        rd_upper && !conv_done |=> !end_of_conversion_flag_r)
        else $error("reading result did not clear end flag");

    a_ctrl_two_read: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_04
        i_rd && i_addr == sar_adc_pkg::OFS_CONV_CONTROL_TWO
        |=> o_rdata[7:6] == 2'h0)
        else $error("control two upper bits not masked");

endmodule // sar_adc_sequencer

// ---- sar_adc_pkg.sv ----
// package: register map, field layouts, reset values and conversion timing for the adc sequencer
package sar_adc_pkg;

    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int CODE_W = 10;
    localparam int CNT_W = 11;

    localparam logic [ADDR_W-1:0] OFS_CONV_CONTROL_ONE = 2'h0;
    localparam logic [ADDR_W-1:0] OFS_CONV_CONTROL_TWO = 2'h1;
    localparam logic [ADDR_W-1:0] OFS_CONV_RESULT_UPPER = 2'h2;
    localparam logic [ADDR_W-1:0] OFS_CONV_RESULT_LOWER_STATUS = 2'h3;

    // result/status register field positions
    localparam int POS_RESULT_LOW = 6;
    localparam int POS_EOC_FLAG = 5;
    localparam int POS_BUSY_FLAG = 4;

    typedef enum logic [1:0] {
        MODE_DISABLED = 2'b00,
        MODE_SOFTWARE = 2'b01,
        MODE_RESERVED = 2'b10,
        MODE_REPEAT = 2'b11
    } conversion_mode_select_t;

    typedef enum logic [2:0] {
        CT_39 = 3'b000,
        CT_RSV_A = 3'b001,
        CT_78 = 3'b010,
        CT_156 = 3'b011,
        CT_312 = 3'b100,
        CT_624 = 3'b101,
        CT_1248 = 3'b110,
        CT_RSV_B = 3'b111
    } conv_time_t;

    typedef struct packed {
        logic conversion_start_bit;
        conversion_mode_select_t conversion_mode_select;
        logic analog_input_disable;
        logic [3:0] input_channel_select;
    } conv_control_one_t;

    typedef struct packed {
        logic [1:0] unused_hi;
        logic ladder_reference_on;
        logic fixed_one;
        conv_time_t conv_time;
        logic fixed_zero;
    } conv_control_two_t;

    localparam logic [DATA_W-1:0] CONV_CONTROL_ONE_RST = 8'h10;
    localparam logic [DATA_W-1:0] CONV_CONTROL_TWO_RST = 8'h00;

    // conversion lengths in high_freq_clock periods (i_mclk is that clock)
    localparam logic [CNT_W-1:0] TICKS_39 = 11'h027;
    localparam logic [CNT_W-1:0] TICKS_78 = 11'h04E;
    localparam logic [CNT_W-1:0] TICKS_156 = 11'h09C;
    localparam logic [CNT_W-1:0] TICKS_312 = 11'h138;
    localparam logic [CNT_W-1:0] TICKS_624 = 11'h270;
    localparam logic [CNT_W-1:0] TICKS_1248 = 11'h4E0;

    // reserved codes fall back to the longest, safest length
    function automatic logic [CNT_W-1:0] conv_ticks(input conv_time_t code);
        logic [CNT_W-1:0] t;
        t = TICKS_1248;
        unique case (code)
            CT_39: t = TICKS_39;
            CT_78: t = TICKS_78;
            CT_156: t = TICKS_156;
            CT_312: t = TICKS_312;
            CT_624: t = TICKS_624;
            CT_1248, CT_RSV_A, CT_RSV_B: t = TICKS_1248;
        endcase
        return t;
    endfunction

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } conv_state_t;

endpackage

// ---- tb_top.sv ----
// testbench for the adc sequencer: bus tasks, directed scenarios and verdict
`timescale 1ns/1ns
module tb_top;
    logic i_mclk;
    logic i_rst_n;
    logic [sar_adc_pkg::ADDR_W-1:0] i_addr;
    logic [sar_adc_pkg::DATA_W-1:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic i_standby;
    logic [sar_adc_pkg::CODE_W-1:0] i_conv_code;
    logic [sar_adc_pkg::DATA_W-1:0] o_rdata;
    logic o_conversion_done_irq;
    logic o_converter_busy_flag;
    logic o_ladder_reference_on;
    logic o_analog_input_disable;
    logic [3:0] o_input_channel_select;
    int mismatches;
    int checks;
    int n;
    int irqs;
    int busys;
    int ct_code[7] = '{0, 2, 3, 4, 5, 6, 1};
    int ct_len[7] = '{39, 78, 156, 312, 624, 1248, 1248};

    sar_adc_sequencer uut (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .i_standby(i_standby),
        .i_conv_code(i_conv_code),
        .o_rdata(o_rdata),
        .o_conversion_done_irq(o_conversion_done_irq),
        .o_converter_busy_flag(o_converter_busy_flag),
        .o_ladder_reference_on(o_ladder_reference_on),
        .o_analog_input_disable(o_analog_input_disable),
        .o_input_channel_select(o_input_channel_select)
    );

    initial
    begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        checks++;
        if (got != exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk8(o_rdata, exp);
    endtask

    // counts busy cycles up to the done pulse, bounded
    task automatic wait_done(output int cnt);
        int k;
        cnt = 0;
        for (k = 0; k < 1400; k++)
        begin
            @(posedge i_mclk);
            #1;
            if (o_converter_busy_flag === 1'b1)
                cnt++;
            if (o_conversion_done_irq === 1'b1)
                break;
        end
        chk8({7'h00, o_conversion_done_irq}, 8'h01);
    endtask

    task automatic watch(input int cyc, output int ni, output int nb);
        ni = 0;
        nb = 0;
        repeat (cyc)
        begin
            @(posedge i_mclk);
            #1;
            if (o_conversion_done_irq !== 1'b0)
                ni++;
            if (o_converter_busy_flag !== 1'b0)
                nb++;
        end
    endtask

    task automatic t_reset();
        rd_chk(sar_adc_pkg::OFS_CONV_CONTROL_ONE, sar_adc_pkg::CONV_CONTROL_ONE_RST);
        rd_chk(sar_adc_pkg::OFS_CONV_CONTROL_TWO, sar_adc_pkg::CONV_CONTROL_TWO_RST);
        chk8({6'h00, o_converter_busy_flag, o_ladder_reference_on}, 8'h00);
    endtask

    task automatic t_times();
        @(posedge i_mclk);
        i_conv_code <= 10'h2D6;
        for (int i = 0; i < 7; i++)
        begin
            wr(2'h1, {2'b00, 1'b1, 1'b1, ct_code[i][2:0], 1'b0});
            wr(2'h0, 8'hA3);
            wait_done(n);
            chk_cnt(n, ct_len[i]);
            chk8({7'h00, o_converter_busy_flag}, 8'h00);
            @(posedge i_mclk);
            #1;
            chk8({7'h00, o_conversion_done_irq}, 8'h00);
            chk8({7'h00, o_ladder_reference_on}, 8'h01);
            rd_chk(2'h3, 8'hA0);
            rd_chk(2'h0, 8'h23);
            rd_chk(2'h2, 8'hB5);
            rd_chk(2'h3, 8'h80);
        end
        chk8({3'h0, o_analog_input_disable, o_input_channel_select}, 8'h03);
    endtask

    task automatic t_restart();
        @(posedge i_mclk);
        i_conv_code <= 10'h0C5;
        wr(2'h1, 8'h10);
        wr(2'h0, 8'hA3);
        wait_done(n);
        @(posedge i_mclk);
        i_conv_code <= 10'h3FE;
        wr(2'h0, 8'hA3);
        repeat (3) @(posedge i_mclk);
        rd_chk(2'h3, 8'h50);
        rd_chk(2'h2, 8'h31);
        wait_done(n);
        rd_chk(2'h2, 8'hFF);
        chk8({7'h00, o_ladder_reference_on}, 8'h00);
    endtask

    task automatic t_repeat();
        @(posedge i_mclk);
        i_conv_code <= 10'h155;
        wr(2'h1, 8'h30);
        wr(2'h0, 8'hE3);
        wait_done(n);
        chk8({7'h00, o_converter_busy_flag}, 8'h01);
        @(posedge i_mclk);
        i_conv_code <= 10'h2AA;
        wait_done(n);
        rd_chk(2'h2, 8'hAA);
        repeat (5) @(posedge i_mclk);
        wr(2'h0, 8'h13);
        i_conv_code <= 10'h000;
        repeat (2) @(posedge i_mclk);
        #1;
        chk8({7'h00, o_converter_busy_flag}, 8'h00);
        watch(60, irqs, busys);
        chk_cnt(irqs, 0);
        rd_chk(2'h2, 8'hAA);
        // reserved mode with start set must not begin a conversion
        wr(2'h0, 8'hC3);
        watch(10, irqs, busys);
        chk_cnt(busys, 0);
        rd_chk(2'h0, 8'hC3);
    endtask

    task automatic t_standby();
        @(posedge i_mclk);
        i_conv_code <= 10'h3FF;
        wr(2'h1, 8'h3C);
        wr(2'h0, 8'hA3);
        repeat (10) @(posedge i_mclk);
        i_standby <= 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
        chk8({7'h00, o_converter_busy_flag}, 8'h00);
        chk8({7'h00, o_ladder_reference_on}, 8'h00);
        chk8({3'h0, o_analog_input_disable, o_input_channel_select}, 8'h10);
        wr(2'h0, 8'hA3);
        wr(2'h1, 8'h3C);
        rd_chk(2'h0, 8'h10);
        rd_chk(2'h1, 8'h00);
        rd_chk(2'h2, 8'h00);
        @(posedge i_mclk);
        i_standby <= 1'b0;
        watch(100, irqs, busys);
        chk_cnt(irqs + busys, 0);
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge i_mclk);
        mismatches++;
        print_verdict();
    end

    initial
    begin
        mismatches = 0;
        checks = 0;
        i_rst_n = 1'b0;
        i_addr = 2'h0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_standby = 1'b0;
        i_conv_code = 10'h000;
        repeat (4) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_reset();
        t_times();
        t_restart();
        t_repeat();
        t_standby();
        print_verdict();
    end
endmodule // tb_top
